// File: core/flash_host_defs.svh
// Constants for the host-side controller of a byte-wide command flash.
// Assumes a 10 MHz core clock; every time but T_LOAD_GUARD is converted to cycles here.
//
// Summary of operation
// - Write 00H selects array read mode
// - 90H then read 0000H/0001H returns codes
// - Chip erase: 30H twice, starts on rise
// - Chip erase done: bit seven 1, six steady
// - Block erase: 20H then D0H with address
// - Further block loads within 30ms, else erase
// - Block erase done: bit seven 1, six steady
// - Program: 40H, then address and data write
// - FFH twice aborts set-up or failure
// - A0H latches erase verify address for read
// - Manual block erase: 60H, 60H with address
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// Command bytes
`define CMD_READ_ARRAY   8'h00
`define CMD_READ_ID      8'h90
`define CMD_AUTO_CHIP    8'h30
`define CMD_AUTO_BLOCK   8'h20
`define CMD_BLOCK_GO     8'hd0
`define CMD_AUTO_PROGRAM 8'h40
`define CMD_MANUAL_BLOCK 8'h60
`define CMD_VERIFY       8'ha0
`define CMD_ABORT        8'hff

// Data bus and address bit positions
`define POLL_BIT         7
`define TOGGLE_BIT       6
`define ADDR_BIT_NINE    9

// Times in their own units and the clock rate
`define CLK_MHZ          10
`define T_WE_PULSE_NS    100
`define T_ACCESS_NS      120
`define T_SUPPLY_NS      1000
`define T_LOAD_WIN_MS    30
`define T_LOAD_GUARD     20

// Cycle counts: least times round up, longest time rounds down
`define WE_CYC   ((`T_WE_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define ACC_CYC  ((`T_ACCESS_NS * `CLK_MHZ + 999) / 1000)
`define SUP_CYC  ((`T_SUPPLY_NS * `CLK_MHZ + 999) / 1000)
`define WIN_CYC  (`T_LOAD_WIN_MS * 1000 * `CLK_MHZ)

`endif

// File: core/flash_host_pkg.sv
// Types shared by the flash host controller and its pin cycle engine.
// Assumes the constants header is compiled alongside.
`default_nettype none
package flash_host_pkg;

   // Operations offered on the command port
   typedef enum logic [3:0] {
      OP_READ, OP_READ_ID, OP_PIN_ID, OP_CHIP_ERASE, OP_BLOCK_ERASE,
      OP_BLOCK_ADD, OP_PROGRAM, OP_ABORT, OP_VERIFY, OP_MANUAL_BLOCK
   } op_t;

   // Command sequence of one operation
   typedef struct packed {
      logic [7:0] first;
      logic [7:0] second;
      logic [1:0] writes;
      logic       read_after;
      logic       poll;
   } plan_t;

   typedef enum logic [2:0] {
      S_IDLE, S_SUPPLY, S_WR1, S_WR2, S_WINDOW, S_READ, S_POLL
   } host_state_t;

   typedef enum logic [2:0] {
      P_IDLE, P_SETUP, P_STROBE, P_HOLD, P_ACCESS, P_SAMPLE
   } pin_state_t;

endpackage : flash_host_pkg
`default_nettype wire

// File: core/flash_cycle_if.sv
// One bus cycle request between the sequencer and the pin engine.
// Assumes both ends run on the same core clock.
`default_nettype none
interface flash_cycle_if;
   logic        req;
   logic        wr;
   logic [16:0] addr;
   logic [7:0]  wdata;
   logic        done;
   logic [7:0]  rdata;

   modport master (output req, output wr, output addr, output wdata,
                   input done, input rdata);
   modport engine (input req, input wr, input addr, input wdata,
                   output done, output rdata);
endinterface : flash_cycle_if
`default_nettype wire

// File: core/flash_pin_cycle.sv
// Pin engine: turns one request into a timed write or read on the
// flash pins. Assumes an asynchronous flash with active-low strobes.
`include "flash_host_defs.svh"
`default_nettype none
module flash_pin_cycle
   import flash_host_pkg::*;
#(
   parameter int WE_CYCLES  = `WE_CYC,
   parameter int ACC_CYCLES = `ACC_CYC
) (
   // Clock and reset
   input  wire logic   core_clk_i,
   input  wire logic   resetn_i,
   // Cycle requests
   flash_cycle_if.engine cyc,
   // Flash pins
   output logic        ce_n_o,
   output logic        oe_n_o,
   output logic        we_n_o,
   output logic [16:0] addr_o,
   output logic [7:0]  dq_o,
   output logic        dq_oe_o,
   input  wire logic [7:0] dq_i
);

   pin_state_t  state;
   logic [7:0]  cnt;
   logic [7:0]  sync1, sync2, sync3;
   logic        stable;
   logic        done;
   logic [7:0]  rdata;

   assign stable    = (sync2 == sync3);
   assign cyc.done  = done;
   assign cyc.rdata = rdata;

   /////////////////////////////////////////////////////////////////////
   // Data pins cross into the clock domain through three stages
   always_ff @(posedge core_clk_i) begin
      sync1 <= dq_i;
      sync2 <= sync1;
      sync3 <= sync2;
   end

   /////////////////////////////////////////////////////////////////////
   // Cycle sequencer; address is set a full cycle before the strobe
   always_ff @(posedge core_clk_i) begin
      done <= 1'b0;
      if (!resetn_i) begin
         state   <= P_IDLE;
         cnt     <= 8'h00;
         ce_n_o  <= 1'b1;
         oe_n_o  <= 1'b1;
         we_n_o  <= 1'b1;
         addr_o  <= 17'h00000;
         dq_o    <= 8'h00;
         dq_oe_o <= 1'b0;
         rdata   <= 8'h00;
      end else begin
         case (state)
            P_IDLE: begin
               // The master still shows the old request while done stands
               if (cyc.req && !done) begin
                  ce_n_o  <= 1'b0;
                  addr_o  <= cyc.addr;
                  dq_o    <= cyc.wdata;
                  dq_oe_o <= cyc.wr;       // Never drive on reads
                  cnt     <= 8'h00;
                  state   <= P_SETUP;
               end
            end
            P_SETUP: begin
               if (cyc.wr) begin
                  we_n_o <= 1'b0;          // Falling edge latches address
                  state  <= P_STROBE;
               end else begin
                  oe_n_o <= 1'b0;
                  state  <= P_ACCESS;
               end
            end
            P_STROBE: begin
               cnt <= cnt + 8'h01;
               if (cnt == 8'(WE_CYCLES - 1)) begin
                  we_n_o <= 1'b1;          // Rising edge latches data
                  state  <= P_HOLD;
               end
            end
            P_HOLD: begin
               ce_n_o  <= 1'b1;
               dq_oe_o <= 1'b0;
               done    <= 1'b1;
               state   <= P_IDLE;
            end
            P_ACCESS: begin
               cnt <= cnt + 8'h01;
               // Allow access time plus the three synchroniser stages
               if (cnt == 8'(ACC_CYCLES + 2))
                  state <= P_SAMPLE;
            end
            P_SAMPLE: begin
               if (stable) begin
                  rdata  <= sync2;
                  oe_n_o <= 1'b1;
                  ce_n_o <= 1'b1;
                  done   <= 1'b1;
                  state  <= P_IDLE;
               end
            end
            default: state <= P_IDLE;
         endcase
      end
   end

endmodule : flash_pin_cycle
`default_nettype wire

// File: core/flash_host.sv
// Host controller for a byte-wide command flash: issues command
// sequences, raises the programming supply and polls for completion.
// Assumes the flash pins are wired directly; the supply and bit-nine
// high-voltage outputs steer external switches.
`include "flash_host_defs.svh"
`default_nettype none
module flash_host
   import flash_host_pkg::*;
#(
   parameter int SUPPLY_CYCLES = `SUP_CYC,
   parameter int LOAD_WINDOW   = `WIN_CYC,
   parameter int POLL_LIMIT    = 65535
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   // Command port
   input  wire logic        cmd_valid_i,
   output logic             cmd_ready_o,
   input  wire op_t         cmd_op_i,
   input  wire logic [16:0] cmd_addr_i,
   input  wire logic [7:0]  cmd_data_i,
   // Results
   output logic             done_o,
   output logic             fail_o,
   output logic [7:0]       rdata_o,
   // Flash pins
   output logic             ce_n_o,
   output logic             oe_n_o,
   output logic             we_n_o,
   output logic [16:0]      addr_o,
   output logic [7:0]       dq_o,
   output logic             dq_oe_o,
   input  wire logic [7:0]  dq_i,
   output logic             supply_high_o,
   output logic             id_high_voltage_o
);

   /////////////////////////////////////////////////////////////////////
   // Command table
   function automatic plan_t plan_of(input op_t op, input logic [7:0] d);
      plan_t p;
      p = '{first: `CMD_READ_ARRAY, second: 8'h00, writes: 2'd1,
            read_after: 1'b1, poll: 1'b0};
      case (op)
         OP_READ_ID: p.first = `CMD_READ_ID;
         OP_PIN_ID:  p.writes = 2'd0;
         OP_CHIP_ERASE: begin
            p = '{`CMD_AUTO_CHIP, `CMD_AUTO_CHIP, 2'd2, 1'b0, 1'b1};
         end
         OP_BLOCK_ERASE: begin
            p = '{`CMD_AUTO_BLOCK, `CMD_BLOCK_GO, 2'd2, 1'b0, 1'b1};
         end
         OP_PROGRAM: begin
            p = '{`CMD_AUTO_PROGRAM, d, 2'd2, 1'b0, 1'b1};
         end
         OP_ABORT: begin
            p = '{`CMD_ABORT, `CMD_ABORT, 2'd2, 1'b0, 1'b0};
         end
         OP_VERIFY: p.first = `CMD_VERIFY;
         OP_MANUAL_BLOCK: begin
            p = '{`CMD_MANUAL_BLOCK, `CMD_MANUAL_BLOCK, 2'd2, 1'b0, 1'b0};
         end
         default: p.first = `CMD_READ_ARRAY;
      endcase
      return p;
   endfunction : plan_of

   flash_cycle_if cyc ();

   host_state_t state;
   op_t         op;
   plan_t       plan;
   logic [16:0] addr;
   logic        expect_poll;
   logic        prev_toggle;
   logic        prev_valid;
   logic [15:0] poll_cnt;
   logic [31:0] cnt;
   logic        poll_ok;
   logic        steady;
   logic        window_open;
   logic        take;
   plan_t       new_plan;

   /////////////////////////////////////////////////////////////////////
   // Request decoding and completion checks
   assign new_plan    = plan_of(cmd_op_i, cmd_data_i);
   assign window_open = (state == S_WINDOW);
   assign cmd_ready_o = (state == S_IDLE) || window_open;
   assign take        = cmd_valid_i && cmd_ready_o;
   assign poll_ok     = cyc.rdata[`POLL_BIT] == expect_poll;
   assign steady      = prev_valid &&
                        (cyc.rdata[`TOGGLE_BIT] == prev_toggle);

   // Pin engine is asked for a cycle in every bus-active state
   assign cyc.req   = (state == S_WR1) || (state == S_WR2) ||
                      (state == S_READ) || (state == S_POLL);
   assign cyc.wr    = (state == S_WR1) || (state == S_WR2);
   assign cyc.wdata = (state == S_WR1) ? plan.first : plan.second;
   assign cyc.addr  = addr;

   /////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge core_clk_i) begin
      done_o <= 1'b0;
      if (!resetn_i) begin
         state             <= S_IDLE;
         op                <= OP_READ;
         plan              <= '0;
         addr              <= 17'h00000;
         expect_poll       <= 1'b1;
         prev_toggle       <= 1'b0;
         prev_valid        <= 1'b0;
         poll_cnt          <= 16'h0000;
         cnt               <= 32'h00000000;
         fail_o            <= 1'b0;
         rdata_o           <= 8'h00;
         supply_high_o     <= 1'b0;          // Low supply keeps it read-only
         id_high_voltage_o <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (take) begin
                  op          <= cmd_op_i;
                  plan        <= new_plan;
                  addr        <= cmd_addr_i;
                  fail_o      <= 1'b0;
                  cnt         <= 32'h00000000;
                  prev_valid  <= 1'b0;
                  poll_cnt    <= 16'h0000;
                  // Program polls for true data, erase for a one
                  expect_poll <= (cmd_op_i == OP_PROGRAM) ?
                                 cmd_data_i[`POLL_BIT] : 1'b1;
                  // Writes need the supply high; pin reads need it low
                  supply_high_o <= (cmd_op_i != OP_PIN_ID);
                  id_high_voltage_o <= (cmd_op_i == OP_PIN_ID);
                  state <= S_SUPPLY;
               end
            end
            S_SUPPLY: begin
               // Let the switched supply settle before any strobe
               cnt <= cnt + 32'h00000001;
               if (cnt == 32'(SUPPLY_CYCLES - 1)) begin
                  cnt   <= 32'h00000000;
                  state <= (plan.writes == 2'd0) ? S_READ : S_WR1;
               end
            end
            S_WR1: begin
               if (cyc.done) begin
                  if (plan.writes == 2'd2)
                     state <= S_WR2;
                  else
                     state <= S_READ;
               end
            end
            S_WR2: begin
               if (cyc.done) begin
                  cnt <= 32'h00000000;
                  if (op == OP_BLOCK_ERASE)
                     state <= S_WINDOW;
                  else if (plan.poll)
                     state <= S_POLL;
                  else begin
                     supply_high_o <= 1'b0;
                     done_o        <= 1'b1;
                     state         <= S_IDLE;
                  end
               end
            end
            S_WINDOW: begin
               // Extra blocks must start loading well inside the window; the host takes them up to and including the cycle cnt equals LOAD_WINDOW
               cnt <= cnt + 32'h00000001;
               if (take && cmd_op_i == OP_BLOCK_ADD) begin
                  addr  <= cmd_addr_i;
                  state <= S_WR2;
               end else if (cnt == 32'(LOAD_WINDOW)) begin
                  state <= S_POLL;                    // Device erases now
               end
            end
            S_READ: begin
               if (cyc.done) begin
                  rdata_o           <= cyc.rdata;
                  supply_high_o     <= 1'b0;
                  id_high_voltage_o <= 1'b0;
                  done_o            <= 1'b1;
                  state             <= S_IDLE;
               end
            end
            S_POLL: begin
               if (cyc.done) begin
                  prev_toggle <= cyc.rdata[`TOGGLE_BIT];
                  prev_valid  <= 1'b1;
                  poll_cnt    <= poll_cnt + 16'h0001;
                  if (poll_ok && steady) begin
                     rdata_o       <= cyc.rdata;
                     supply_high_o <= 1'b0;
                     done_o        <= 1'b1;
                     state         <= S_IDLE;
                  end else if (poll_cnt == 16'(POLL_LIMIT)) begin
                     // Give up and abort with two reset writes
                     fail_o <= 1'b1;
                     plan   <= plan_of(OP_ABORT, 8'h00);
                     op     <= OP_ABORT;
                     state  <= S_WR1;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   /////////////////////////////////////////////////////////////////////
   // Pin engine
   flash_pin_cycle #(
      .WE_CYCLES  (`WE_CYC),
      .ACC_CYCLES (`ACC_CYC)
   ) u_pins (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .cyc        (cyc.engine),
      .ce_n_o     (ce_n_o),
      .oe_n_o     (oe_n_o),
      .we_n_o     (we_n_o),
      .addr_o     (addr_o),
      .dq_o       (dq_o),
      .dq_oe_o    (dq_oe_o),
      .dq_i       (dq_i)
   );

endmodule : flash_host
`default_nettype wire

// File: tb/flash_host_props.sv
// Pin-level assertions on the flash host controller.
// Assumes it is bound to every flash_host instance.
`default_nettype none
module flash_host_props (
   // Clock and reset
   input wire logic        core_clk_i,
   input wire logic        resetn_i,
   // Command port and results
   input wire logic        cmd_ready_o,
   input wire logic        done_o,
   input wire logic        fail_o,
   // Flash pins
   input wire logic        ce_n_o,
   input wire logic        oe_n_o,
   input wire logic        we_n_o,
   input wire logic [16:0] addr_o,
   input wire logic [7:0]  dq_o,
   input wire logic        dq_oe_o,
   input wire logic        supply_high_o,
   input wire logic        id_high_voltage_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   // Write strobe is one cycle with address and data held across it
   sequence wr_pulse;
      !we_n_o ##1 we_n_o && dq_oe_o && $stable(dq_o) && $stable(addr_o);
   endsequence
   sequence wr_setup;
      oe_n_o && !ce_n_o && dq_oe_o;
   endsequence

   sup_gate_a: assert property (!we_n_o |-> supply_high_o)
      else $error("write strobe without supply");
   wr_shape_a: assert property ($fell(we_n_o) |-> wr_setup ##0 wr_pulse)
      else $error("write cycle malformed");
   bus_free_a: assert property (!oe_n_o |-> !dq_oe_o && we_n_o && !ce_n_o)
      else $error("read with host driving bus");
   id_low_a: assert property (id_high_voltage_o |-> !supply_high_o)
      else $error("id voltage with supply high");
   done_one_a: assert property (done_o |=> !done_o && cmd_ready_o)
      else $error("done not single or not ready");
   abort_end_a: assert property ($rose(fail_o) |-> ##[1:60] done_o)
      else $error("abort did not finish");
   abort_data_a: assert property (fail_o && $fell(we_n_o) |-> dq_o == 8'hff)
      else $error("abort wrote wrong byte");
   sup_wait_a: assert property ($rose(supply_high_o) |-> we_n_o [*8])
      else $error("write too soon after supply");
   rd_len_a: assert property ($fell(oe_n_o) |-> (!oe_n_o && !ce_n_o) [*3])
      else $error("read cycle too short");
endmodule : flash_host_props

bind flash_host flash_host_props i_props (.core_clk_i, .resetn_i,
   .cmd_ready_o, .done_o, .fail_o, .ce_n_o, .oe_n_o, .we_n_o, .addr_o,
   .dq_o, .dq_oe_o, .supply_high_o, .id_high_voltage_o);
`default_nettype wire

// File: tb/flash_dev_model.sv
// Behavioural byte-wide command flash facing the host's pins.
// Assumes the bench resolves the shared data bus from both enables.
`default_nettype none
module flash_dev_model #(
   parameter logic [7:0] MAKER  = 8'h3c, // Arbitrary code
   parameter logic [7:0] PART   = 8'h96, // Arbitrary code
   parameter int         WIN_NS = 5000
) (
   // Flash pins
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic [16:0] addr_i,
   input  wire logic [7:0]  dq_i,
   input  wire logic        vpp_hi_i,
   input  wire logic        id_hv_i,
   // Busy status lasts this many reads plus one; 8'hff never completes
   input  wire logic [7:0]  busy_len_i,
   output logic [7:0]       dq_o,
   output logic             dq_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  mem [0:131071];
   logic [7:0]  cmd = 8'h00, prev = 8'h00, left = 8'h00;
   logic [16:0] la = 17'h00000;
   logic        busy = 0, ers = 0, tog = 0, pbit = 0, ld = 0;
   realtime     t_up = 0;

   task automatic go(input logic e);
      busy = 1;
      ers = e;
      tog = 0;
      left = busy_len_i;
   endtask : go

   initial foreach (mem[i]) mem[i] = 8'hff;
   ////////////////////////////////////////////////////////////////////
   // Supply drop forces array read so nothing spurious alters memory
   always @(negedge vpp_hi_i) begin
      cmd = 8'h00;
      prev = 8'h00;
   end
   // Address on the falling strobe; a late load closes loading
   always @(negedge we_n_i) begin
      la = addr_i;
      if ($realtime - t_up > WIN_NS) ld = 0;
   end
   // Commands act on the rising strobe, only with the supply high
   always @(posedge we_n_i) begin
      t_up = $realtime;
      if (!ce_n_i && vpp_hi_i) begin
         if (dq_i == 8'hff && prev == 8'hff) begin
            busy = 0;
            cmd = 8'h00;
         end else if (prev == 8'h30 && dq_i == 8'h30) begin
            foreach (mem[i]) mem[i] = 8'hff;
            go(1'b1);
         end else if (dq_i == 8'hd0 && (prev == 8'h20 || ld)) begin
            for (int i = 0; i < 16384; i++)
               mem[{la[16:14], i[13:0]}] = 8'hff;
            ld = 1;
            go(1'b1);
         end else if (prev == 8'h40) begin
            mem[la] = mem[la] & dq_i;
            pbit = dq_i[7];
            go(1'b0);
         end else if (!busy) cmd = dq_i;
         prev = (prev == 8'h40) ? 8'h00 : dq_i;
      end
   end
   // Each finished read advances the busy phase
   always @(posedge oe_n_i) begin
      if (busy) begin
         tog = ~tog;
         if (busy_len_i != 8'hff) begin
            if (left == 8'h00) busy = 0;
            else left = left - 8'h01;
         end
      end
   end
   // Status while busy, codes in identification, else array data
   assign dq_o = busy ? {ers ? 1'b0 : ~pbit, tog, 6'h00}
      : (id_hv_i || (vpp_hi_i && cmd == 8'h90))
      ? (addr_i[0] ? PART : MAKER) : mem[addr_i];
   assign dq_oe_o = !ce_n_i && !oe_n_i && we_n_i;
endmodule : flash_dev_model
`default_nettype wire

// File: tb/flash_host_bench.sv
// Self-checking bench: flash host controller against a device model.
// Assumes package, interface, design, model and checker compiled first.
`default_nettype none
module flash_host_bench;
   import flash_host_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] MAKER = 8'h3c; // Arbitrary code
   localparam logic [7:0] PART  = 8'h96; // Arbitrary code
   logic        clk = 0, rst_n = 0, valid = 0;
   op_t         op = OP_READ;
   logic [16:0] a = 17'h00000, pin_addr;
   logic [7:0]  d = 8'h00, busy_len = 8'h01, flt = 8'h5a, bus;
   logic [7:0]  rdata, hq, mq;
   logic        ce_n, oe_n, we_n, dq_oe, vpp, idhv, ready, done, fail;
   logic        m_oe;
   int          errors = 0, checks_done = 0;

   always #50 clk = ~clk;
   // A released bus changes every cycle rather than holding a value
   always @(posedge clk) flt <= ~flt;
   assign bus = m_oe ? mq : dq_oe ? hq : flt;

   flash_host #(.LOAD_WINDOW(50), .POLL_LIMIT(20)) i_dut (
      .core_clk_i(clk), .resetn_i(rst_n), .cmd_valid_i(valid),
      .cmd_ready_o(ready), .cmd_op_i(op), .cmd_addr_i(a), .cmd_data_i(d),
      .done_o(done), .fail_o(fail), .rdata_o(rdata), .ce_n_o(ce_n),
      .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(pin_addr), .dq_o(hq),
      .dq_oe_o(dq_oe), .dq_i(bus), .supply_high_o(vpp),
      .id_high_voltage_o(idhv));
   flash_dev_model #(.MAKER(MAKER), .PART(PART), .WIN_NS(5000)) i_dev (
      .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(pin_addr),
      .dq_i(bus), .vpp_hi_i(vpp), .id_hv_i(idhv),
      .busy_len_i(busy_len), .dq_o(mq), .dq_oe_o(m_oe));

   task automatic chk8(input logic [7:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s: got %b want %b", $time, what, got, exp);
      end
   endtask : chk1
   // Hold the request from one falling edge until it is taken
   task automatic issue(input op_t o, input logic [16:0] ad,
                        input logic [7:0] dt);
      int n;
      n = 0;
      @(negedge clk);
      valid = 1;
      op = o;
      a = ad;
      d = dt;
      @(posedge clk);
      while (ready !== 1'b1 && n < 500) begin
         n++;
         @(posedge clk);
      end
      chk1(ready, 1'b1, "request taken");
      @(negedge clk);
      valid = 0;
   endtask : issue
   task automatic wait_done;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 5000) begin
         n++;
         @(negedge clk);
      end
      chk1(done, 1'b1, "completion");
   endtask : wait_done
   task automatic run(input op_t o, input logic [16:0] ad,
                      input logic [7:0] dt);
      issue(o, ad, dt);
      wait_done;
   endtask : run
   ////////////////////////////////////////////////////////////////////
   task automatic sc_ident;
      run(OP_READ_ID, 17'h00000, 8'h00);
      chk8(rdata, MAKER, "maker by command");
      run(OP_READ_ID, 17'h00001, 8'h00);
      chk8(rdata, PART, "part by command");
      run(OP_PIN_ID, 17'h1fc00, 8'h00);
      chk8(rdata, MAKER, "maker by pin");
      run(OP_PIN_ID, 17'h00201, 8'h00);
      chk8(rdata, PART, "part by pin");
   endtask : sc_ident
   task automatic sc_program;
      busy_len = 8'h02;
      run(OP_PROGRAM, 17'h00123, 8'h5a);
      chk1(fail, 1'b0, "program status");
      run(OP_READ, 17'h00123, 8'h00);
      chk8(rdata, 8'h5a, "programmed byte");
   endtask : sc_program
   task automatic sc_chip;
      busy_len = 8'h06;
      run(OP_CHIP_ERASE, 17'h00000, 8'h00);
      chk1(fail, 1'b0, "chip erase status");
      run(OP_READ, 17'h00123, 8'h00);
      chk8(rdata, 8'hff, "chip erased");
   endtask : sc_chip
   // Two blocks loaded within the window; a third must survive
   task automatic sc_block;
      int n;
      n = 0;
      busy_len = 8'h03;
      run(OP_PROGRAM, 17'h00123, 8'h00);
      run(OP_PROGRAM, 17'h08010, 8'h00);
      run(OP_PROGRAM, 17'h1f000, 8'h00);
      issue(OP_BLOCK_ERASE, 17'h00123, 8'h00);
      while (ready !== 1'b1 && n < 500) begin
         n++;
         @(negedge clk);
      end
      chk1(ready, 1'b1, "load window open");
      issue(OP_BLOCK_ADD, 17'h08010, 8'h00);
      wait_done;
      chk1(fail, 1'b0, "block erase status");
      run(OP_READ, 17'h00123, 8'h00);
      chk8(rdata, 8'hff, "first block");
      run(OP_READ, 17'h08010, 8'h00);
      chk8(rdata, 8'hff, "added block");
      run(OP_READ, 17'h1f000, 8'h00);
      chk8(rdata, 8'h00, "unselected block");
   endtask : sc_block
   // Verify, manual block set-up and a plain reset pair
   task automatic sc_cmds;
      run(OP_VERIFY, 17'h08010, 8'h00);
      chk8(rdata, 8'hff, "verify erased byte");
      run(OP_MANUAL_BLOCK, 17'h1f000, 8'h00);
      chk1(fail, 1'b0, "manual block status");
      run(OP_ABORT, 17'h00000, 8'h00);
      run(OP_READ, 17'h1f000, 8'h00);
      chk8(rdata, 8'h00, "abort kept data");
   endtask : sc_cmds
   // Device never completes, so the host must give up and abort
   task automatic sc_abort;
      busy_len = 8'hff;
      run(OP_PROGRAM, 17'h0f0f0, 8'h3c);
      chk1(fail, 1'b1, "timeout flagged");
      busy_len = 8'h01;
      run(OP_READ, 17'h0f0f0, 8'h00);
      chk1(fail, 1'b0, "flag cleared");
   endtask : sc_abort

   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1;
      sc_ident;
      sc_program;
      sc_chip;
      sc_block;
      sc_cmds;
      sc_abort;
      give_verdict;
   end
   // Whole run needs well under 10000 cycles
   initial begin
      #2000000;
      errors++;
      give_verdict;
   end
endmodule : flash_host_bench
`default_nettype wire
